/* hw/tmr_timer_block.v */
// Timers 0/1 with mode register and timer 2 auto-reload, AHB-Lite slave
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "tmr_regs.vh"
module tmr_timer_block (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	// External pins
	input wire extIrq0Pin,
	input wire extIrq1Pin,
	input wire t0CountPin,
	input wire t1CountPin,
	input wire t2CountPin,
	input wire t2TriggerPin,
	// Interrupt request
	output reg irq
);
// ****************************************
// Declarations
// ****************************************
reg [7:0] timer01ModeConfig_r;
reg [5:0] ctrl_r;
reg [7:0] clockControlReg_r;
reg [7:0] t0LowByte_r;
reg [7:0] t0HighByte_r;
reg [7:0] t1LowByte_r;
reg [7:0] t1HighByte_r;
reg [15:0] t2Count_r;
reg [15:0] t2Capture_r;
reg [3:0] status_r;
reg [3:0] mask_r;
reg [3:0] div_r;
reg wrPhase_r;
reg rdPend_r;
reg [7:0] addr_r;
reg [31:0] rdData;
reg [3:0] status_nxt;
wire [5:0] pinLvl;
wire [5:0] pinFall;
// ****************************************
// Step function shared by timers 0 and 1
// ****************************************
// Returns {overflow, high byte, low byte}
function [16:0] tmrStep;
	input [7:0] lo;
	input [7:0] hi;
	input [1:0] mode;
	reg [13:0] s13;
	reg [16:0] s16;
	reg [8:0] s8;
	begin
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h00001;
		s8 = {1'b0, lo} + 9'h001;
		case (mode)
			`TMR_M13:
				tmrStep = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
			`TMR_M16:
				tmrStep = s16;
			`TMR_M8AR:
				tmrStep = {s8[8], hi, s8[8] ? hi : s8[7:0]};
			default:
				tmrStep = {s8[8], hi, s8[7:0]};
		endcase
	end
endfunction
// ****************************************
// Pin synchronisers
// ****************************************
// Bits: 0 irq0, 1 irq1, 2 t0, 3 t1, 4 t2 count, 5 t2 trigger
tmr_pin_sync #(
	.W(6)
) uPinSync (
	.clock(clock),
	.resetn(resetn),
	.pinIn({t2TriggerPin, t2CountPin, t1CountPin, t0CountPin, extIrq1Pin, extIrq0Pin}),
	.pinLevel(pinLvl),
	.pinFall(pinFall)
);
// ****************************************
// Field decode
// ****************************************
wire [1:0] t0ModeField = timer01ModeConfig_r[`TMR_MODE_T0M];
wire [1:0] t1ModeField = timer01ModeConfig_r[`TMR_MODE_T1M];
wire t0GateEnable = timer01ModeConfig_r[`TMR_MODE_T0GATE];
wire t1GateEnable = timer01ModeConfig_r[`TMR_MODE_T1GATE];
wire t0CountSelect = timer01ModeConfig_r[`TMR_MODE_T0CT];
wire t1CountSelect = timer01ModeConfig_r[`TMR_MODE_T1CT];
wire t0RunBit = ctrl_r[`TMR_CTRL_RUN0];
wire t1RunBit = ctrl_r[`TMR_CTRL_RUN1];
wire t2RunBit = ctrl_r[`TMR_CTRL_RUN2];
wire t2CountSelect = ctrl_r[`TMR_CTRL_CT2];
wire t2ExternalEnable = ctrl_r[`TMR_CTRL_T2_EXTERNAL_ENABLE];
wire t2CaptureReloadSelect = ctrl_r[`TMR_CTRL_CPRL2];
wire t0PrescaleSelect = clockControlReg_r[`TMR_CLK_T0M];
wire t1PrescaleSelect = clockControlReg_r[`TMR_CLK_T1M];
wire t0Split = (t0ModeField == `TMR_MSPLIT);
// ****************************************
// Prescaler: divide-by-12 enable
// ****************************************
wire tick12 = (div_r == `TMR_PRESCALE_LAST);
always @(posedge clock or negedge resetn)
begin
	if (!resetn)
		div_r <= 4'h0;
	else if (tick12)
		div_r <= 4'h0;
	else
		div_r <= div_r + 4'h1;
end
// ****************************************
// Count enables
// ****************************************
// Internal tick per timer: full clock or clock/12
wire t0Tick = t0PrescaleSelect | tick12;
wire t1Tick = t1PrescaleSelect | tick12;
// Timer 0 source and gate
wire t0Src = t0CountSelect ? pinFall[2] : t0Tick;
wire t0Gate = ~t0GateEnable | pinLvl[0];
wire t0En = t0RunBit & t0Gate & t0Src;
// Timer 1 loses its pin while timer 0 is split
wire t1Src = (t1CountSelect & ~t0Split) ? pinFall[3] : t1Tick;
wire t1Gate = ~t1GateEnable | pinLvl[1];
wire t1Stop = (t1ModeField == `TMR_MSPLIT);
wire t1En = t1RunBit & t1Gate & t1Src & ~t1Stop;
// Split high byte: internal clock, timer 1 run bit
wire t0HiEn = t0Split & t1RunBit & t0Tick;
// Timer 2 source
wire t2Src = t2CountSelect ? pinFall[4] : 1'b1;
wire t2En = t2RunBit & t2Src;
wire t2Trig = t2ExternalEnable & pinFall[5];
// ****************************************
// Next counts and events
// ****************************************
wire [16:0] t0Step = tmrStep(t0LowByte_r, t0HighByte_r, t0ModeField);
wire [16:0] t1Step = tmrStep(t1LowByte_r, t1HighByte_r, t1ModeField);
wire [8:0] t0HiInc = {1'b0, t0HighByte_r} + 9'h001;
wire t2Top = (t2Count_r == `TMR_T2_TOP);
wire t2Ovf = t2En & t2Top;
wire tf0Set = t0En & t0Step[16];
// Timer 1 flag belongs to the split high byte in mode 3
wire tf1Set = (t1En & t1Step[16] & ~t0Split) | (t0HiEn & t0HiInc[8]);
wire tf2Set = t2Ovf;
wire exf2Set = t2Trig;
// ****************************************
// AHB-Lite bus interface
// ****************************************
wire accept = hsel & htrans[1] & hready;
wire wrEn = wrPhase_r;
wire wrMode = wrEn & (addr_r == `TMR_OFS_MODE);
wire wrCtrl = wrEn & (addr_r == `TMR_OFS_CTRL);
wire wrClk = wrEn & (addr_r == `TMR_OFS_CLKCTL);
wire wrT0 = wrEn & (addr_r == `TMR_OFS_T0);
wire wrT1 = wrEn & (addr_r == `TMR_OFS_T1);
wire wrT2 = wrEn & (addr_r == `TMR_OFS_T2);
wire wrCap = wrEn & (addr_r == `TMR_OFS_CAP2);
wire wrStat = wrEn & (addr_r == `TMR_OFS_STAT);
wire wrMask = wrEn & (addr_r == `TMR_OFS_MASK);
// Address phase capture; reads add one wait state
always @(posedge clock or negedge resetn)
begin
	if (!resetn)
	begin
		wrPhase_r <= 1'b0;
		rdPend_r <= 1'b0;
		addr_r <= 8'h00;
		hreadyout <= 1'b1;
		hrdata <= 32'h00000000;
		hresp <= 1'b0;
	end
	else
	begin
		wrPhase_r <= accept & hwrite;
		rdPend_r <= accept & ~hwrite;
		if (accept)
			addr_r <= {haddr[7:2], 2'b00};
		hreadyout <= ~(accept & ~hwrite);
		if (rdPend_r)
			hrdata <= rdData;
	end
end
// Read mux; unmapped offsets read zero
always @*
begin
	rdData = 32'h00000000;
	case (addr_r)
		`TMR_OFS_MODE:
			rdData[7:0] = timer01ModeConfig_r;
		`TMR_OFS_CTRL:
			rdData[5:0] = ctrl_r;
		`TMR_OFS_CLKCTL:
			rdData[7:0] = clockControlReg_r;
		`TMR_OFS_T0:
			rdData[15:0] = {t0HighByte_r, t0LowByte_r};
		`TMR_OFS_T1:
			rdData[15:0] = {t1HighByte_r, t1LowByte_r};
		`TMR_OFS_T2:
			rdData[15:0] = t2Count_r;
		`TMR_OFS_CAP2:
			rdData[15:0] = t2Capture_r;
		`TMR_OFS_STAT:
			rdData[3:0] = status_r;
		`TMR_OFS_MASK:
			rdData[3:0] = mask_r;
		default:
			rdData = 32'h00000000;
	endcase
end
// ****************************************
// Configuration registers
// ****************************************
always @(posedge clock or negedge resetn)
begin
	if (!resetn)
	begin
		timer01ModeConfig_r <= `TMR_RST_MODE;
		ctrl_r <= `TMR_RST_CTRL;
		clockControlReg_r <= `TMR_RST_CLK;
		mask_r <= `TMR_RST_FLAGS;
	end
	else
	begin
		if (wrMode)
			timer01ModeConfig_r <= hwdata[7:0];
		if (wrCtrl)
			ctrl_r <= hwdata[5:0];
		if (wrClk)
			clockControlReg_r <= hwdata[7:0];
		if (wrMask)
			mask_r <= hwdata[3:0];
	end
end
// ****************************************
// Timer 0: software write beats counting
// ****************************************
always @(posedge clock or negedge resetn)
begin
	if (!resetn)
	begin
		t0LowByte_r <= `TMR_RST_BYTE;
		t0HighByte_r <= `TMR_RST_BYTE;
	end
	else if (wrT0)
	begin
		t0LowByte_r <= hwdata[7:0];
		t0HighByte_r <= hwdata[15:8];
	end
	else
	begin
		if (t0En)
		begin
			t0LowByte_r <= t0Step[7:0];
			t0HighByte_r <= t0Step[15:8];
		end
		if (t0HiEn)
			t0HighByte_r <= t0HiInc[7:0];
	end
end
// ****************************************
// Timer 1
// ****************************************
always @(posedge clock or negedge resetn)
begin
	if (!resetn)
	begin
		t1LowByte_r <= `TMR_RST_BYTE;
		t1HighByte_r <= `TMR_RST_BYTE;
	end
	else if (wrT1)
	begin
		t1LowByte_r <= hwdata[7:0];
		t1HighByte_r <= hwdata[15:8];
	end
	else if (t1En)
	begin
		t1LowByte_r <= t1Step[7:0];
		t1HighByte_r <= t1Step[15:8];
	end
end
// ****************************************
// Timer 2 count and capture pair
// ****************************************
always @(posedge clock or negedge resetn)
begin
	if (!resetn)
	begin
		t2Count_r <= `TMR_RST_WORD;
		t2Capture_r <= `TMR_RST_WORD;
	end
	else
	begin
		if (wrT2)
			t2Count_r <= hwdata[15:0];
		else if (~t2CaptureReloadSelect & (t2Ovf | t2Trig))
			t2Count_r <= t2Capture_r;
		else if (t2En)
			t2Count_r <= t2Count_r + 16'h0001;
		// Capture mode latches the count on a trigger edge
		if (wrCap)
			t2Capture_r <= hwdata[15:0];
		else if (t2CaptureReloadSelect & t2Trig)
			t2Capture_r <= t2Count_r;
	end
end
// ****************************************
// Sticky status, write one to clear, set wins
// ****************************************
always @*
begin
	status_nxt = status_r;
	if (wrStat)
		status_nxt = status_r & ~hwdata[3:0];
	if (tf0Set)
		status_nxt[`TMR_ST_TF0] = 1'b1;
	if (tf1Set)
		status_nxt[`TMR_ST_TF1] = 1'b1;
	if (tf2Set)
		status_nxt[`TMR_ST_TF2] = 1'b1;
	if (exf2Set)
		status_nxt[`TMR_ST_EXF2] = 1'b1;
end
always @(posedge clock or negedge resetn)
begin
	if (!resetn)
	begin
		status_r <= `TMR_RST_FLAGS;
		irq <= 1'b0;
	end
	else
	begin
		status_r <= status_nxt;
		irq <= |(status_r & mask_r);
	end
end

endmodule // tmr_timer_block

/* hw/tmr_regs.vh */
// Register map, field positions, reset values and counts of the timer block
`ifndef TMR_REGS_VH
`define TMR_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define TMR_OFS_MODE 8'h00
`define TMR_OFS_CTRL 8'h04
`define TMR_OFS_CLKCTL 8'h08
`define TMR_OFS_T0 8'h0C
`define TMR_OFS_T1 8'h10
`define TMR_OFS_T2 8'h14
`define TMR_OFS_CAP2 8'h18
`define TMR_OFS_STAT 8'h1C
`define TMR_OFS_MASK 8'h20

// ****************************************
// Field positions
// ****************************************
`define TMR_MODE_T0M 1:0
`define TMR_MODE_T0CT 2
`define TMR_MODE_T0GATE 3
`define TMR_MODE_T1M 5:4
`define TMR_MODE_T1CT 6
`define TMR_MODE_T1GATE 7
`define TMR_CTRL_RUN0 0
`define TMR_CTRL_RUN1 1
`define TMR_CTRL_RUN2 2
`define TMR_CTRL_CT2 3
`define TMR_CTRL_T2_EXTERNAL_ENABLE 4
`define TMR_CTRL_CPRL2 5
`define TMR_CLK_T0M 3
`define TMR_CLK_T1M 4
`define TMR_ST_TF0 0
`define TMR_ST_TF1 1
`define TMR_ST_TF2 2
`define TMR_ST_EXF2 3

// ****************************************
// Mode codes
// ****************************************
`define TMR_M13 2'h0
`define TMR_M16 2'h1
`define TMR_M8AR 2'h2
`define TMR_MSPLIT 2'h3

// ****************************************
// Reset values and counts
// ****************************************
`define TMR_RST_MODE 8'h00
`define TMR_RST_CTRL 6'h00
`define TMR_RST_CLK 8'h00
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000
`define TMR_RST_FLAGS 4'h0
`define TMR_PRESCALE_LAST 4'hB
`define TMR_T2_TOP 16'hFFFF

`endif

/* hw/tmr_pin_sync.v */
// Two-stage pin synchroniser with falling-edge detect
`timescale 1ns/100ps
module tmr_pin_sync #(
	parameter W = 6
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Raw pins
	input wire [W-1:0] pinIn,
	// Synchronised level and edge pulse
	output wire [W-1:0] pinLevel,
	output wire [W-1:0] pinFall
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;
reg [W-1:0] prev_r;

// Meta stage feeds only the second stage
always @(posedge clock or negedge resetn)
begin
	if (!resetn)
	begin
		meta_r <= {W{1'b1}};
		sync_r <= {W{1'b1}};
		prev_r <= {W{1'b1}};
	end
	else
	begin
		meta_r <= pinIn;
		sync_r <= meta_r;
		prev_r <= sync_r;
	end
end

// High-to-low seen on the synchronised level
assign pinLevel = sync_r;
assign pinFall = prev_r & ~sync_r;

endmodule // tmr_pin_sync

/* testbench/tmr_props.sv */
// Bus protocol and register checks for the timer block
`timescale 1ns/100ps
`include "tmr_regs.vh"
module tmr_props (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Bus
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire [31:0] hrdata,
	input wire hresp,
	// Interrupt
	input wire irq
);
	logic dpOn_r;
	logic dpWr_r;
	logic [7:0] dpAdr_r;
	logic [7:0] mode_r;
	logic [5:0] ctrl_r;
	logic [3:0] mask_r;
	wire taken = hsel && htrans[1] && hready;
	wire rdDone = dpOn_r && !dpWr_r && hreadyout;
	wire wrEnd = dpOn_r && dpWr_r && hreadyout;
	// Track the data phase and shadow the written mode, control and mask registers
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			dpOn_r <= 1'b0;
			dpWr_r <= 1'b0;
			dpAdr_r <= 8'h00;
			mode_r <= 8'h00;
			ctrl_r <= 6'h00;
			mask_r <= 4'h0;
		end
		else
		begin
			dpOn_r <= taken | (dpOn_r & ~hreadyout);
			if (taken) dpWr_r <= hwrite;
			if (taken) dpAdr_r <= {haddr[7:2], 2'h0};
			if (wrEnd && dpAdr_r == `TMR_OFS_MODE) mode_r <= hwdata[7:0];
			if (wrEnd && dpAdr_r == `TMR_OFS_CTRL) ctrl_r <= hwdata[5:0];
			if (wrEnd && dpAdr_r == `TMR_OFS_MASK) mask_r <= hwdata[3:0];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// ****************************************
	// Properties
	// ****************************************
	AST_RD_WAIT: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	AST_WR_NOWAIT: assert property (taken && hwrite |=> hreadyout)
		else $error("write stalled");
	AST_LOW_ONE: assert property (!hreadyout |=> hreadyout)
		else $error("wait longer than one cycle");
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("response not okay");
	AST_HRDATA_HOLD: assert property ($changed(hrdata) |-> rdDone)
		else $error("read data moved outside a read");
	AST_MODE_RB: assert property (rdDone && dpAdr_r == `TMR_OFS_MODE |-> hrdata == {24'h0, mode_r})
		else $error("mode register readback wrong");
	AST_CTRL_RB: assert property (rdDone && dpAdr_r == `TMR_OFS_CTRL |-> hrdata == {26'h0, ctrl_r})
		else $error("control register readback wrong");
	AST_MASK_RB: assert property (rdDone && dpAdr_r == `TMR_OFS_MASK |-> hrdata == {28'h0, mask_r})
		else $error("mask register readback wrong");
	AST_IRQ_GATED: assert property (irq |-> mask_r != 4'h0 || $past(mask_r) != 4'h0)
		else $error("interrupt with all sources masked");
	AST_UNMAPPED: assert property (rdDone && dpAdr_r > `TMR_OFS_MASK |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // tmr_props

/* testbench/tb_timer_mode_and_autoreload.sv */
// Self-checking bench for the timer block
`timescale 1ns/100ps
`include "tmr_regs.vh"
module tb_timer_mode_and_autoreload;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic rdPend = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [5:0] pins = 6'h3F;
	logic [31:0] rs = 32'h48;
	logic [31:0] v;
	logic [15:0] cap;
	logic [31:0] expQ[$];
	logic [7:0] tm[3] = '{8'h04, 8'h06, 8'h07};
	logic [15:0] ti[3] = '{16'hFFFF, 16'h80FF, 16'h12FF};
	logic [15:0] te[3] = '{16'h00E0, 16'h8080, 16'h1200};
	int num_errors = 0;
	int cmp_count = 0;
	wire hreadyout;
	wire hresp;
	wire irq;
	wire [31:0] hrdata;
	// Clock of 100 ns
	always #50 clock = ~clock;
	tmr_timer_block dut_u (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .extIrq0Pin(pins[0]), .extIrq1Pin(pins[1]), .t0CountPin(pins[2]),
		.t1CountPin(pins[3]), .t2CountPin(pins[4]), .t2TriggerPin(pins[5]), .irq(irq));
	// ****************************************
	// Helpers
	// ****************************************
	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chkWord(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bounded wait for ready at a rising edge
	task waitRdy;
		int n;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100)
		begin
			num_errors++;
			print_verdict;
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		waitRdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdPend <= !w;
		waitRdy;
		rdPend <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	// Falling pulse held three clocks, then settle
	task pulse(input int p);
		pins[p] <= 1'b0;
		repeat (3) @(posedge clock);
		pins[p] <= 1'b1;
		repeat (6) @(posedge clock);
	endtask
	// Read data monitor takes the oldest expectation
	always @(posedge clock)
	begin
		if (rdPend && hreadyout === 1'b1)
		begin
			// A read with no expectation noted counts as a mismatch
			if (expQ.size() == 0)
				num_errors++;
			else
				chkWord(hrdata, expQ.pop_front());
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 10; i++) rd(i == 9 ? 8'h3C : 8'(i * 4), 32'h0);
		wr(8'h3C, rnd());
		rd(8'h3C, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			v = (rnd() & 32'hCC) | (i * 32'h11);
			wr(`TMR_OFS_MODE, v);
			rd(`TMR_OFS_MODE, v);
		end
		$display("test mode fields done");
		v = rnd();
		cap = {1'b0, v[14:0]};
		wr(`TMR_OFS_CAP2, {16'h0, cap});
		wr(`TMR_OFS_T2, 32'hFFFF);
		wr(`TMR_OFS_MASK, 32'h4);
		wr(`TMR_OFS_CTRL, 32'h0C); // Run and count pin, auto-reload
		pulse(4);
		rd(`TMR_OFS_T2, {16'h0, cap});
		rd(`TMR_OFS_STAT, 32'h4);
		chkWord({31'h0, irq}, 32'h1);
		pulse(4);
		rd(`TMR_OFS_T2, {16'h0, cap + 16'h1});
		wr(`TMR_OFS_STAT, 32'h4);
		wr(`TMR_OFS_MASK, 32'h0);
		rd(`TMR_OFS_STAT, 32'h0);
		wr(`TMR_OFS_T2, 32'hFFFF);
		pulse(4);
		rd(`TMR_OFS_STAT, 32'h4);
		chkWord({31'h0, irq}, 32'h0);
		wr(`TMR_OFS_STAT, 32'hF);
		$display("test overflow reload done");
		wr(`TMR_OFS_T2, 32'h5);
		pulse(5);
		rd(`TMR_OFS_T2, 32'h5);
		rd(`TMR_OFS_STAT, 32'h0);
		wr(`TMR_OFS_CTRL, 32'h1C); // External trigger enabled
		pulse(5);
		rd(`TMR_OFS_T2, {16'h0, cap});
		rd(`TMR_OFS_STAT, 32'h8);
		wr(`TMR_OFS_MODE, 32'h0D); // Mode first, so no stale random mode counts
		wr(`TMR_OFS_CTRL, 32'h1);
		$display("test trigger done");
		pins[0] <= 1'b0;
		pulse(2);
		rd(`TMR_OFS_T0, 32'h0);
		pins[0] <= 1'b1;
		pulse(2);
		rd(`TMR_OFS_T0, 32'h1);
		pins[0] <= 1'b0;
		wr(`TMR_OFS_MODE, 32'h05);
		pulse(2);
		rd(`TMR_OFS_T0, 32'h2);
		for (int i = 0; i < 3; i++)
		begin
			wr(`TMR_OFS_STAT, 32'hF);
			wr(`TMR_OFS_MODE, {24'h0, tm[i]});
			wr(`TMR_OFS_T0, {16'h0, ti[i]});
			pulse(2);
			rd(`TMR_OFS_T0, {16'h0, te[i]});
			rd(`TMR_OFS_STAT, 32'h1);
		end
		$display("test timer 0 modes done");
		// Split high byte runs on timer 1's run bit for exactly two clocks
		wr(`TMR_OFS_CLKCTL, 32'h8);
		wr(`TMR_OFS_T0, 32'hFE00);
		wr(`TMR_OFS_STAT, 32'hF);
		wr(`TMR_OFS_CTRL, 32'h3);
		wr(`TMR_OFS_CTRL, 32'h1);
		rd(`TMR_OFS_T0, 32'h0);
		rd(`TMR_OFS_STAT, 32'h2);
		// Timer 1 stands still in mode 3 and counts in mode 1
		wr(`TMR_OFS_CTRL, 32'h0);
		wr(`TMR_OFS_CLKCTL, 32'h18);
		wr(`TMR_OFS_T0, 32'h0);
		wr(`TMR_OFS_T1, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			wr(`TMR_OFS_MODE, i ? 32'h11 : 32'h31);
			wr(`TMR_OFS_CTRL, 32'h3);
			wr(`TMR_OFS_CTRL, 32'h0);
			rd(`TMR_OFS_T0, 32'(2 + 2 * i));
			rd(`TMR_OFS_T1, 32'(2 * i));
		end
		wr(`TMR_OFS_MODE, 32'h51);
		wr(`TMR_OFS_CTRL, 32'h2);
		pulse(3);
		rd(`TMR_OFS_T1, 32'h3);
		// Divide-by-12 tick seen on exactly 24 counting edges
		wr(`TMR_OFS_CLKCTL, 32'h0);
		wr(`TMR_OFS_T0, 32'h0);
		wr(`TMR_OFS_CTRL, 32'h1);
		repeat (22) @(posedge clock);
		wr(`TMR_OFS_CTRL, 32'h0);
		rd(`TMR_OFS_T0, 32'h2);
		$display("test prescale and timer 1 done");
		// Timer 2 on the system clock, then capture on a trigger edge
		wr(`TMR_OFS_T2, 32'h0);
		wr(`TMR_OFS_CTRL, 32'h4);
		wr(`TMR_OFS_CTRL, 32'h0);
		rd(`TMR_OFS_T2, 32'h2);
		v = rnd();
		wr(`TMR_OFS_STAT, 32'hF);
		wr(`TMR_OFS_T2, {16'h0, v[15:0]});
		wr(`TMR_OFS_CTRL, 32'h30);
		pulse(5);
		rd(`TMR_OFS_CAP2, {16'h0, v[15:0]});
		rd(`TMR_OFS_T2, {16'h0, v[15:0]});
		rd(`TMR_OFS_STAT, 32'h8);
		$display("test timer 2 clock and capture done");
		@(posedge clock);
		if (expQ.size() != 0) num_errors++;
		print_verdict;
	end
endmodule // tb_timer_mode_and_autoreload
bind tmr_timer_block tmr_props u_props (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp), .irq(irq));
